// file: core/wwdt_pkg.sv
// Constants and types for the windowed watchdog timer
package wwdt_pkg;
	localparam int unsigned ADDR_W      = 8;
	localparam int unsigned IDX_W       = 2;
	localparam int unsigned CNT_W       = 14;
	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CTRL   = 2'h0;
	localparam logic [IDX_W-1:0] IDX_STATUS = 2'h1;
	localparam logic [IDX_W-1:0] IDX_PROT   = 2'h2;
	localparam logic [IDX_W-1:0] IDX_LAST   = 2'h2;
	// Field layout
	localparam int unsigned PER_LSB     = 0;
	localparam int unsigned WIN_LSB     = 4;
	localparam int unsigned LOCK_BIT    = 7;
	localparam int unsigned SYNC_BIT    = 0;
	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	localparam logic [3:0]  CODE_OFF    = 4'h0;
	localparam logic [3:0]  CODE_MAX    = 4'hb;
	localparam int unsigned TICK_SHIFT  = 2;
	// Timed write protection
	localparam logic [7:0]  PROT_KEY    = 8'hc3;
	localparam logic [2:0]  PROT_CYCLES = 3'h4;
	// Crossing of control writes and clears, in counter ticks
	localparam logic [1:0]  SYNC_LAST   = 2'h1;
	// Bus answers
	localparam logic [1:0]  RESP_OKAY   = 2'b00;
	localparam logic [1:0]  RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_NORMAL,
		ST_FIRST,
		ST_CLOSED,
		ST_OPEN
	} wwdt_state_t;

	function automatic logic wwdt_code_ok(input logic [3:0] code);
		return (code != CODE_OFF) && (code <= CODE_MAX);
	endfunction

	function automatic logic [CNT_W-1:0] wwdt_ticks(input logic [3:0] code);
		return CNT_W'(1) << (code + 4'(TICK_SHIFT));
	endfunction
endpackage

// file: core/wwdt_reg_if.sv
// Register access carrier between bus slave and watchdog core
`timescale 1ns/1ps
`default_nettype none
interface wwdt_reg_if;
	import wwdt_pkg::*;
	logic             wr_en;
	logic [IDX_W-1:0] wr_idx;
	logic [7:0]       wr_data;
	logic [IDX_W-1:0] rd_idx;
	logic [7:0]       rd_data;

	modport slave (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
	modport regs  (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface
`default_nettype wire

// file: core/wwdt_axil_slave.sv
// AXI4-Lite slave for the watchdog registers
`timescale 1ns/1ps
`default_nettype none
module wwdt_axil_slave (
	// Clock and reset
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst,
	// Write channels
	input  wire logic [wwdt_pkg::ADDR_W-1:0] i_awaddr,
	input  wire logic                   i_awvalid,
	output logic                        o_awready,
	input  wire logic [31:0]            i_wdata,
	input  wire logic [3:0]             i_wstrb,
	input  wire logic                   i_wvalid,
	output logic                        o_wready,
	output logic [1:0]                  o_bresp,
	output logic                        o_bvalid,
	input  wire logic                   i_bready,
	// Read channels
	input  wire logic [wwdt_pkg::ADDR_W-1:0] i_araddr,
	input  wire logic                   i_arvalid,
	output logic                        o_arready,
	output logic [31:0]                 o_rdata,
	output logic [1:0]                  o_rresp,
	output logic                        o_rvalid,
	input  wire logic                   i_rready,
	// Register side
	wwdt_reg_if.slave                   bus
);
	import wwdt_pkg::*;

	logic                aw_got_r;
	logic                w_got_r;
	logic [ADDR_W-1:0]   awaddr_r;
	logic [7:0]          wdata_r;
	logic                wlane_r;
	logic                aw_take;
	logic                w_take;
	logic                aw_have;
	logic                w_have;
	logic                do_wr;
	logic                b_hold;
	logic                ar_take;
	logic                r_hold;
	logic [ADDR_W-1:0]   wa;

	assign aw_take = i_awvalid & o_awready;
	assign w_take  = i_wvalid & o_wready;
	assign aw_have = aw_got_r | aw_take;
	assign w_have  = w_got_r | w_take;
	assign do_wr   = aw_have & w_have & ~o_bvalid;
	assign b_hold  = do_wr | (o_bvalid & ~i_bready);
	assign wa      = aw_take ? i_awaddr : awaddr_r;
	assign ar_take = i_arvalid & o_arready;
	assign r_hold  = ar_take | (o_rvalid & ~i_rready);

	assign bus.wr_en   = do_wr & (w_take ? i_wstrb[0] : wlane_r)
		& (wa[ADDR_W-1:IDX_W+2] == '0) & (wa[IDX_W+1:2] <= IDX_LAST);
	assign bus.wr_idx  = wa[IDX_W+1:2];
	assign bus.wr_data = w_take ? i_wdata[7:0] : wdata_r;
	assign bus.rd_idx  = i_araddr[IDX_W+1:2];

	// Write path
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= '0;
			wlane_r   <= 1'b0;
			o_awready <= 1'b0;
			o_wready  <= 1'b0;
			o_bvalid  <= 1'b0;
			o_bresp   <= RESP_OKAY;
		end else begin
			aw_got_r  <= aw_have & ~do_wr;
			w_got_r   <= w_have & ~do_wr;
			o_awready <= ~(aw_have & ~do_wr) & ~b_hold;
			o_wready  <= ~(w_have & ~do_wr) & ~b_hold;
			o_bvalid  <= b_hold;
			if (aw_take) begin
				awaddr_r <= i_awaddr;
			end
			if (w_take) begin
				wdata_r <= i_wdata[7:0];
				wlane_r <= i_wstrb[0];
			end
			if (do_wr) begin
				o_bresp <= ((wa[ADDR_W-1:IDX_W+2] == '0)
					&& (wa[IDX_W+1:2] <= IDX_LAST)) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Read path
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= '0;
			o_rresp   <= RESP_OKAY;
		end else begin
			o_arready <= ~r_hold;
			o_rvalid  <= r_hold;
			if (ar_take) begin
				if ((i_araddr[ADDR_W-1:IDX_W+2] == '0)
					&& (i_araddr[IDX_W+1:2] <= IDX_LAST)) begin
					o_rdata <= {24'h000000, bus.rd_data};
					o_rresp <= RESP_OKAY;
				end else begin
					o_rdata <= '0;
					o_rresp <= RESP_SLVERR;
				end
			end
		end
	end
endmodule // wwdt_axil_slave
`default_nettype wire

// file: core/wwdt_top.sv
// Windowed watchdog timer core with register file
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module wwdt_top (
	// Clock and reset
	input  wire logic                        i_core_clk,
	input  wire logic                        i_rst,
	// AXI4-Lite write
	input  wire logic [wwdt_pkg::ADDR_W-1:0] i_s_axi_awaddr,
	input  wire logic                        i_s_axi_awvalid,
	output logic                             o_s_axi_awready,
	input  wire logic [31:0]                 i_s_axi_wdata,
	input  wire logic [3:0]                  i_s_axi_wstrb,
	input  wire logic                        i_s_axi_wvalid,
	output logic                             o_s_axi_wready,
	output logic [1:0]                       o_s_axi_bresp,
	output logic                             o_s_axi_bvalid,
	input  wire logic                        i_s_axi_bready,
	// AXI4-Lite read
	input  wire logic [wwdt_pkg::ADDR_W-1:0] i_s_axi_araddr,
	input  wire logic                        i_s_axi_arvalid,
	output logic                             o_s_axi_arready,
	output logic [31:0]                      o_s_axi_rdata,
	output logic [1:0]                       o_s_axi_rresp,
	output logic                             o_s_axi_rvalid,
	input  wire logic                        i_s_axi_rready,
	// Counter clock from the low-power oscillator
	input  wire logic                        i_wdt_counter_clk,
	// CPU side
	input  wire logic                        i_clear_instr,
	input  wire logic                        i_debug_halt,
	// System reset request
	output logic                             o_sys_reset
);
	import wwdt_pkg::*;

	wwdt_reg_if bus ();

	wwdt_axil_slave u_slave (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_awaddr   (i_s_axi_awaddr),
		.i_awvalid  (i_s_axi_awvalid),
		.o_awready  (o_s_axi_awready),
		.i_wdata    (i_s_axi_wdata),
		.i_wstrb    (i_s_axi_wstrb),
		.i_wvalid   (i_s_axi_wvalid),
		.o_wready   (o_s_axi_wready),
		.o_bresp    (o_s_axi_bresp),
		.o_bvalid   (o_s_axi_bvalid),
		.i_bready   (i_s_axi_bready),
		.i_araddr   (i_s_axi_araddr),
		.i_arvalid  (i_s_axi_arvalid),
		.o_arready  (o_s_axi_arready),
		.o_rdata    (o_s_axi_rdata),
		.o_rresp    (o_s_axi_rresp),
		.o_rvalid   (o_s_axi_rvalid),
		.i_rready   (i_s_axi_rready),
		.bus        (bus)
	);

	logic              osc_s1_r;
	logic              osc_s2_r;
	logic              osc_s3_r;
	logic              tick;
	logic [7:0]        cfg_r;
	logic [7:0]        shadow_r;
	logic              pend_r;
	logic [1:0]        pend_cnt_r;
	logic              cfg_apply;
	logic              clr_pend_r;
	logic [1:0]        clr_cnt_r;
	logic              clr_apply;
	logic              lock_r;
	logic [2:0]        prot_cnt_r;
	logic              prot_ok;
	logic              ctrl_wr;
	logic              lock_wr;
	logic              key_wr;
	logic              halted_r;
	logic [3:0]        per_code;
	logic [3:0]        win_code;
	logic              ena;
	logic              win;
	logic [7:0]        cfg_eff;
	logic              ena_eff;
	logic              win_eff;
	logic [CNT_W-1:0]  per_lim;
	logic [CNT_W-1:0]  win_lim;
	logic [CNT_W-1:0]  lim;
	wwdt_state_t       state_r;
	wwdt_state_t       state_nxt;
	logic [CNT_W-1:0]  cnt_r;
	logic [CNT_W-1:0]  cnt_nxt;
	logic              trip;

	// Oscillator edge into the core clock
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
		end else begin
			osc_s1_r <= i_wdt_counter_clk;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end
	assign tick = osc_s2_r & ~osc_s3_r;

	// Register decode
	assign prot_ok = (prot_cnt_r != '0);
	assign key_wr  = bus.wr_en && (bus.wr_idx == IDX_PROT)
		&& (bus.wr_data == PROT_KEY);
	assign ctrl_wr = bus.wr_en && (bus.wr_idx == IDX_CTRL) && prot_ok
		&& !lock_r && !pend_r;
	assign lock_wr = bus.wr_en && (bus.wr_idx == IDX_STATUS) && prot_ok
		&& bus.wr_data[LOCK_BIT];

	always_comb begin
		bus.rd_data = 8'h00;
		unique case (bus.rd_idx)
			IDX_CTRL:   bus.rd_data = cfg_r;
			IDX_STATUS: begin
				bus.rd_data[LOCK_BIT] = lock_r;
				bus.rd_data[SYNC_BIT] = pend_r;
			end
			default:    bus.rd_data = 8'h00;
		endcase
	end

	// Timed write protection window
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			prot_cnt_r <= '0;
		end else if (key_wr) begin
			prot_cnt_r <= PROT_CYCLES;
		end else if (ctrl_wr || lock_wr) begin
			prot_cnt_r <= '0;
		end else if (prot_ok) begin
			prot_cnt_r <= prot_cnt_r - 3'h1;
		end
	end

	// Lock bit
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			lock_r <= 1'b0;
		end else if (halted_r) begin
			lock_r <= 1'b0;
		end else if (lock_wr) begin
			lock_r <= 1'b1;
		end
	end

	// Control write crossing into counter ticks
	assign cfg_apply = pend_r && tick && (pend_cnt_r == SYNC_LAST);
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			cfg_r      <= CTRL_RESET;
			shadow_r   <= CTRL_RESET;
			pend_r     <= 1'b0;
			pend_cnt_r <= '0;
		end else if (ctrl_wr) begin
			shadow_r   <= bus.wr_data;
			pend_r     <= 1'b1;
			pend_cnt_r <= '0;
		end else if (cfg_apply) begin
			cfg_r      <= shadow_r;
			pend_r     <= 1'b0;
		end else if (pend_r && tick) begin
			pend_cnt_r <= pend_cnt_r + 2'h1;
		end
	end

	// Clear instruction crossing; repeats in transit are dropped
	assign clr_apply = clr_pend_r && tick && (clr_cnt_r == SYNC_LAST);
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			clr_pend_r <= 1'b0;
			clr_cnt_r  <= '0;
		end else if (clr_apply) begin
			clr_pend_r <= 1'b0;
		end else if (clr_pend_r) begin
			if (tick) begin
				clr_cnt_r <= clr_cnt_r + 2'h1;
			end
		end else if (i_clear_instr && !halted_r) begin
			clr_pend_r <= 1'b1;
			clr_cnt_r  <= '0;
		end
	end

	// Debug halt tracking
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			halted_r <= 1'b0;
		end else begin
			halted_r <= i_debug_halt;
		end
	end

	// Mode and limits from the control register alone
	assign per_code = cfg_r[PER_LSB +: 4];
	assign win_code = cfg_r[WIN_LSB +: 4];
	assign ena      = wwdt_code_ok(per_code);
	assign win      = wwdt_code_ok(win_code);
	assign per_lim  = wwdt_ticks(per_code);
	assign win_lim  = wwdt_ticks(win_code);
	assign lim      = (state_r == ST_CLOSED) ? win_lim : per_lim;
	// Mode decided from the value that is being applied
	assign cfg_eff  = cfg_apply ? shadow_r : cfg_r;
	assign ena_eff  = wwdt_code_ok(cfg_eff[PER_LSB +: 4]);
	assign win_eff  = wwdt_code_ok(cfg_eff[WIN_LSB +: 4]);

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		trip      = 1'b0;
		if (!ena_eff) begin
			state_nxt = ST_OFF;
			cnt_nxt   = '0;
		end else if (halted_r) begin
			cnt_nxt = '0;
			if (!i_debug_halt || cfg_apply) begin
				state_nxt = win_eff ? ST_FIRST : ST_NORMAL;
			end
		end else if (cfg_apply) begin
			cnt_nxt   = '0;
			state_nxt = win_eff ? ST_FIRST : ST_NORMAL;
		end else if (clr_apply) begin
			cnt_nxt = '0;
			unique case (state_r)
				ST_CLOSED: trip = 1'b1;
				ST_FIRST,
				ST_OPEN:   state_nxt = ST_CLOSED;
				ST_NORMAL: state_nxt = ST_NORMAL;
				ST_OFF:    state_nxt = win_eff ? ST_FIRST : ST_NORMAL;
			endcase
		end else if (tick) begin
			if (state_r == ST_OFF) begin
				state_nxt = win_eff ? ST_FIRST : ST_NORMAL;
			end else if (cnt_r == lim - CNT_W'(1)) begin
				cnt_nxt = '0;
				if (state_r == ST_CLOSED) begin
					state_nxt = ST_OPEN;
				end else begin
					trip = 1'b1;
				end
			end else begin
				cnt_nxt = cnt_r + CNT_W'(1);
			end
		end
	end

	// Counter and phase
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state_r <= ST_OFF;
			cnt_r   <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// System reset request, held until the system reset arrives
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_sys_reset <= 1'b0;
		end else if (trip) begin
			o_sys_reset <= 1'b1;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	sequence timeout_hit;
		ena && !halted_r && !cfg_apply && !clr_apply && tick
			&& (state_r == ST_NORMAL) && (cnt_r == per_lim - CNT_W'(1));
	endsequence

	timeout_reset_a: assert property (timeout_hit |=> o_sys_reset)
		else $error("Missed timeout reset");
	period_span_a: assert property (
		((per_code == 4'h1) |-> (per_lim == CNT_W'(8)))
		and ((per_code == 4'hb) |-> (per_lim == CNT_W'(8192))))
		else $error("Period length wrong");
	tick_pulse_a: assert property (tick |=> !tick)
		else $error("Tick longer than one cycle");
	ctrl_sync_a: assert property (ctrl_wr |=> pend_r && $stable(cfg_r))
		else $error("Control write took effect early");
	clear_restart_a: assert property (
		ena && !halted_r && !cfg_apply && clr_apply
		&& (state_r == ST_NORMAL) |=> (cnt_r == '0) && !o_sys_reset)
		else $error("Clear did not restart");
	mode_source_a: assert property (
		(state_r inside {ST_FIRST, ST_CLOSED, ST_OPEN}) |-> win)
		else $error("Window phase without window code");
	early_clear_a: assert property (
		ena && !halted_r && !cfg_apply && clr_apply
		&& (state_r == ST_CLOSED) |=> o_sys_reset)
		else $error("Early clear not punished");
	first_clear_a: assert property (
		(state_r == ST_FIRST) && !clr_apply |=> (state_r != ST_CLOSED))
		else $error("Closed period before first clear");
	halt_hold_a: assert property (
		halted_r ##1 halted_r |-> (cnt_r == '0) && $stable(o_sys_reset))
		else $error("Counting during halt");
	halt_clear_a: assert property (halted_r && ena |=> cnt_r == '0)
		else $error("Counter not cleared on halt");
	resume_norm_a: assert property (
		halted_r && !i_debug_halt && ena && win |=> state_r == ST_FIRST)
		else $error("Resume did not skip closed period");
	lock_hold_a: assert property (
		lock_r && !halted_r |=> lock_r && !$past(ctrl_wr))
		else $error("Lock lost or bypassed");
	clear_drop_a: assert property (
		clr_pend_r && !clr_apply |=> clr_pend_r
		&& ($stable(clr_cnt_r) || (clr_cnt_r == $past(clr_cnt_r) + 2'h1)))
		else $error("Clear in transit disturbed");
endmodule // wwdt_top
`default_nettype wire

// file: verif/wwdt_cpu_model.sv
// CPU core model issuing watchdog clear instructions
`timescale 1ns/1ps
`default_nettype none
module wwdt_cpu_model (
	// Clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rst,
	// Request from the bench
	input  wire logic       i_req,
	input  wire logic [7:0] i_delay,
	// Clear instruction pulse
	output logic            o_clear
);
	logic [8:0] cnt_r;

	// Clear goes out a chosen number of cycles after the request
	always_ff @(posedge i_core_clk) begin
		o_clear <= 1'b0;
		if (i_rst) begin
			cnt_r <= '0;
		end else if (i_req) begin
			cnt_r <= {1'b1, i_delay};
		end else if (cnt_r[8]) begin
			if (cnt_r[7:0] == 8'h00) begin
				o_clear <= 1'b1;
				cnt_r   <= '0;
			end else begin
				cnt_r <= cnt_r - 9'h001;
			end
		end
	end
endmodule // wwdt_cpu_model
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the windowed watchdog timer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import wwdt_pkg::*;
	logic        i_core_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        cclk = 1'b0;
	logic [7:0]  aw = '0;
	logic [7:0]  ar = '0;
	logic [31:0] wd = '0;
	logic [3:0]  ws = '0;
	logic        awv = 1'b0, wv = 1'b0, bre = 1'b0;
	logic        arv = 1'b0, rre = 1'b0;
	logic        halt = 1'b0, req = 1'b0;
	logic [7:0]  dly = '0;
	logic        clr, awr, wr, bv, arr, rv, srst;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] rd, v;
	int          n_tick = 0;
	int          n_mismatch = 0;
	int          compares = 0;
	int          n = 0;

	always #2.5 i_core_clk = ~i_core_clk;
	initial begin
		#13;
		forever #40 cclk = ~cclk;
	end
	always @(posedge cclk) n_tick <= n_tick + 1;

	wwdt_top u_wwdt_top (
		.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_s_axi_awaddr(aw), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
		.i_s_axi_wdata(wd), .i_s_axi_wstrb(ws), .i_s_axi_wvalid(wv),
		.o_s_axi_wready(wr), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv),
		.i_s_axi_bready(bre), .i_s_axi_araddr(ar), .i_s_axi_arvalid(arv),
		.o_s_axi_arready(arr), .o_s_axi_rdata(rd), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rv), .i_s_axi_rready(rre),
		.i_wdt_counter_clk(cclk), .i_clear_instr(clr),
		.i_debug_halt(halt), .o_sys_reset(srst)
	);
	wwdt_cpu_model u_wwdt_cpu_model (
		.i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(req),
		.i_delay(dly), .o_clear(clr)
	);

	task automatic end_sim;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic tmo(input string what);
		n_mismatch++;
		$display("ERROR %s expected done seen timeout", what);
		end_sim();
	endtask
	task automatic chk(input string s, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	function automatic int exp_ticks(input int c);
		return 1 << (c + 2);
	endfunction
	function automatic int near(input int s, input int e);
		return (s >= e - 1 && s <= e + 1) ? e : s;
	endfunction
	task automatic do_reset;
		@(posedge i_core_clk);
		i_rst <= 1'b1;
		halt <= 1'b0;
		repeat (8) @(posedge i_core_clk);
		i_rst <= 1'b0;
		repeat (2) @(posedge i_core_clk);
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
		int k;
		@(posedge i_core_clk);
		aw <= a;
		wd <= {24'h0, d};
		ws <= 4'hf;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge i_core_clk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wr)
				wv <= 1'b0;
			if (bv)
				break;
		end
		bre <= 1'b0;
		r = bresp;
		if (k == 50)
			tmo("write");
	endtask
	task automatic axi_rd(input logic [7:0] a);
		int k;
		@(posedge i_core_clk);
		ar <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge i_core_clk);
			if (arv && arr)
				arv <= 1'b0;
			if (rv)
				break;
		end
		rre <= 1'b0;
		v = rd;
		r = rresp;
		if (k == 50)
			tmo("read");
	endtask
	task automatic set_ctrl(input logic [7:0] d);
		int k;
		axi_wr(8'h08, PROT_KEY);
		axi_wr(8'h00, d);
		axi_rd(8'h04);
		chk("sync pending", 32'h1, 32'(v[0]));
		for (k = 0; k < 40 && v[0] !== 1'b0; k++)
			axi_rd(8'h04);
		if (k == 40)
			tmo("sync");
	endtask
	task automatic ticks(input int t);
		repeat (t) @(posedge cclk);
		@(posedge i_core_clk);
	endtask
	task automatic clear(input logic [7:0] d);
		@(posedge i_core_clk);
		req <= 1'b1;
		dly <= d;
		@(posedge i_core_clk);
		req <= 1'b0;
		repeat (int'(d) + 3) @(posedge i_core_clk);
	endtask
	task automatic wait_rst(input int lim);
		int t0;
		t0 = n_tick;
		while (srst !== 1'b1 && n_tick - t0 < lim)
			@(posedge i_core_clk);
		n = n_tick - t0;
	endtask

	initial begin
		#490000;
		tmo("run");
	end

	initial begin
		void'($urandom(32'h803a));
		do_reset();
		chk("reset out", 32'h0, 32'(srst));
		for (int i = 0; i < 3; i++) begin
			axi_rd(8'(i * 4));
			chk("reset value", 32'h0, v);
			chk("read resp", 32'(RESP_OKAY), 32'(r));
		end
		axi_rd(8'((3 + $urandom % 61) * 4));
		chk("unmapped rdata", 32'h0, v);
		chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
		axi_wr(8'h0c, 8'($urandom));
		chk("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
		axi_wr(8'h00, 8'h11);
		axi_rd(8'h00);
		chk("unkeyed ctrl", 32'h0, v);
		axi_rd(8'h04);
		chk("unkeyed sync", 32'h0, v);
		do_reset();
		set_ctrl(8'(12 + $urandom % 4));
		wait_rst(100);
		chk("reserved code", 32'h0, 32'(srst));
		$display("test registers done");
		for (int c = 1; c <= 5; c++) begin
			do_reset();
			set_ctrl({(c == 3) ? 4'(12 + $urandom % 4) : 4'h0, 4'(c)});
			wait_rst(exp_ticks(c) + 8);
			chk("timeout", 32'(exp_ticks(c)), 32'(near(n, exp_ticks(c))));
		end
		$display("test timeouts done");
		do_reset();
		set_ctrl(8'h02);
		for (int i = 0; i < 6; i++) begin
			ticks(5 + $urandom % 5);
			clear(8'($urandom % 8));
		end
		chk("kept alive", 32'h0, 32'(srst));
		wait_rst(40);
		chk("clear restart", 32'd18, 32'(near(n, 18)));
		$display("test clears done");
		do_reset();
		set_ctrl(8'h11);
		clear(8'h00);
		ticks(1);
		clear(8'h08);
		ticks(13);
		clear(8'h00);
		ticks(3);
		chk("open clear", 32'h0, 32'(srst));
		clear(8'h00);
		wait_rst(6);
		chk("early clear", 32'h1, 32'(srst));
		$display("test window done");
		do_reset();
		set_ctrl(8'h12);
		ticks(12);
		halt <= 1'b1;
		ticks(3);
		halt <= 1'b0;
		ticks(12);
		chk("halt clears", 32'h0, 32'(srst));
		axi_wr(8'h08, PROT_KEY);
		axi_wr(8'h04, 8'h80);
		axi_rd(8'h04);
		chk("lock set", 32'h80, v);
		axi_wr(8'h08, PROT_KEY);
		axi_wr(8'h00, 8'h00);
		axi_rd(8'h00);
		chk("locked ctrl", 32'h12, v);
		axi_rd(8'h04);
		chk("locked sync", 32'h80, v);
		halt <= 1'b1;
		ticks(40);
		chk("halted", 32'h0, 32'(srst));
		axi_rd(8'h04);
		chk("lock cleared", 32'h0, v);
		halt <= 1'b0;
		ticks(3);
		clear(8'h00);
		ticks(6);
		chk("resume", 32'h0, 32'(srst));
		$display("test debug done");
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
